// File: hdl/eeprom_link_pkg.sv
// shared constants and types for the serial memory link
package eeprom_link_pkg;
	// ----------------------------------------
	// control byte and array
	// ----------------------------------------
	localparam logic [3:0] TYPE_CODE = 4'ha;
	localparam int ADDR_W = 12;
	localparam int DEPTH = 4096;
	localparam logic [11:0] ADDR_TOP = 12'hfff;
	localparam logic [11:0] ADDR_RST = 12'h000;
	localparam int DIR_BIT = 0;
	localparam int SEL_LSB = 1;
	localparam int TYPE_LSB = 4;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int REF_CLK_NS = 50;
	localparam int SCL_HALF_NS = 1000;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam int WRITE_CYCLE_US = 5000;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * 1000 / REF_CLK_NS;
	localparam int BUF_DEPTH = 2;
	// ----------------------------------------
	// host commands
	// ----------------------------------------
	typedef enum logic [1:0] {
		CMD_WRITE = 2'b00,
		CMD_CUR_READ = 2'b01,
		CMD_RAND_READ = 2'b10,
		CMD_POLL = 2'b11
	} host_cmd_t;
endpackage : eeprom_link_pkg

// File: hdl/eeprom_link_if.sv
// two-wire link between host and memory device
`timescale 1ns/100ps
interface eeprom_link_if;
	logic scl;
	logic sda_host_oe;
	logic sda_dev_oe;
	wire sda_line;
	assign sda_line = ~(sda_host_oe | sda_dev_oe);
	modport host (output scl, output sda_host_oe, input sda_line);
	modport dev (input scl, output sda_dev_oe, input sda_line);
endinterface : eeprom_link_if

// File: hdl/eeprom_dev.sv
// memory device end: control decode, pointer, reads, busy withhold
//
// Overview of operation
// - no acknowledge while write cycle runs
// - host polls with start plus write byte
// - acknowledge poll once write cycle done
// - read control byte has direction one
// - pointer holds last address plus one; a write at a page end leaves it at the start of that 32-byte page
// - acknowledge read byte, shift data out
// - nack and stop end single read
// - pointer loaded before repeated start
// - read after repeated start uses loaded address
// - after random read pointer is next
// - host ack requests next consecutive byte
// - host ends sequential read with nack
// - pointer increments after each byte
// - pointer wraps from top to zero; after a write only the low five bits roll over, within the page
// - control byte: type, selects, direction
// - two address bytes, high first, 12 used
// - release data line after host nack
`timescale 1ns/100ps
module eeprom_dev
	import eeprom_link_pkg::*;
#(
	parameter int WRITE_CYC = WRITE_CYCLE_CYC
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// link
	eeprom_link_if.dev LINK,
	// chip select straps
	input wire logic CHIP_SELECT_HIGH_BIT,
	input wire logic CHIP_SELECT_MID_BIT,
	input wire logic CHIP_SELECT_LOW_BIT,
	// status
	output logic BUSY
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CTRL = 3'b001,
		ST_ADDR_HI = 3'b010,
		ST_ADDR_LO = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK = 3'b110
	} dev_state_t;

	logic [7:0] mem [DEPTH];
	logic [1:0] scl_sync_reg, sda_sync_reg;
	logic scl_d_reg, sda_d_reg;
	dev_state_t state_reg, state_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh_reg, sh_next;
	logic [11:0] ptr_reg, ptr_next;
	logic [3:0] ahi_reg, ahi_next;
	logic ack_reg, ack_next;
	logic drive_reg, drive_next;
	logic pend_reg, pend_next;
	logic [31:0] busy_cnt_reg, busy_cnt_next;
	logic we;
	logic [11:0] we_addr;
	logic [7:0] we_data;
	logic scl, sda, scl_rise, scl_fall, start_c, stop_c, sel_ok;

	function automatic logic [11:0] ptr_inc(input logic [11:0] p);
		ptr_inc = (p == ADDR_TOP) ? ADDR_RST : p + 12'h001;
	endfunction : ptr_inc

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], LINK.scl};
			sda_sync_reg <= {sda_sync_reg[0], LINK.sda_line};
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
		end
	end
	assign scl = scl_sync_reg[1];
	assign sda = sda_sync_reg[1];
	assign scl_rise = scl & ~scl_d_reg;
	assign scl_fall = ~scl & scl_d_reg;
	assign start_c = scl & scl_d_reg & sda_d_reg & ~sda;
	assign stop_c = scl & scl_d_reg & ~sda_d_reg & sda;
	assign sel_ok = (sh_reg[7:TYPE_LSB] == TYPE_CODE) &&
		(sh_reg[3:SEL_LSB] == {CHIP_SELECT_HIGH_BIT,
		CHIP_SELECT_MID_BIT, CHIP_SELECT_LOW_BIT});

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		ptr_next = ptr_reg;
		ahi_next = ahi_reg;
		ack_next = ack_reg;
		drive_next = drive_reg;
		pend_next = pend_reg;
		busy_cnt_next = busy_cnt_reg;
		we = 1'b0;
		we_addr = ptr_reg;
		we_data = sh_reg;
		if (busy_cnt_reg != 0)
			busy_cnt_next = busy_cnt_reg - 32'd1;
		if (start_c) begin
			state_next = ST_CTRL;
			bit_next = 4'd0;
			drive_next = 1'b0;
			ack_next = 1'b0;
		end else if (stop_c) begin
			state_next = ST_IDLE;
			drive_next = 1'b0;
			ack_next = 1'b0;
			if (pend_reg)
				busy_cnt_next = WRITE_CYC;
			pend_next = 1'b0;
		end else if (state_reg != ST_IDLE) begin
			if (scl_rise && !ack_reg && state_reg != ST_RDATA) begin
				sh_next = {sh_reg[6:0], sda};
				bit_next = bit_reg + 4'd1;
			end
			if (scl_rise && state_reg == ST_RDATA) begin
				bit_next = bit_reg + 4'd1;
				if (ack_reg) begin
					// host answer on ninth clock
					ack_next = 1'b0;
					bit_next = 4'd0;
					if (sda)
						state_next = ST_IDLE;
					else
						sh_next = mem[ptr_reg];
				end
			end
			if (scl_fall) begin
				if (ack_reg) begin
					// end of our acknowledge slot
					ack_next = 1'b0;
					drive_next = 1'b0;
					bit_next = 4'd0;
					if (state_reg == ST_RDATA)
						drive_next = ~sh_reg[7];
				end else if (state_reg == ST_RDATA) begin
					if (bit_reg == 4'd8) begin
						drive_next = 1'b0;
						ack_next = 1'b1;
						ptr_next = ptr_inc(ptr_reg);
					end else begin
						drive_next = ~sh_reg[7 - bit_reg[2:0]];
					end
					if (bit_reg == 4'd0 && state_reg == ST_RDATA && drive_reg
						== 1'b0 && sh_reg[7] == 1'b0 && bit_reg != 4'd8)
						drive_next = 1'b1;
				end else if (bit_reg == 4'd8) begin
					bit_next = 4'd0;
					case (state_reg)
					ST_CTRL: begin
						if (!sel_ok || busy_cnt_reg != 0) begin
							state_next = ST_IDLE;
						end else begin
							drive_next = 1'b1;
							ack_next = 1'b1;
							if (sh_reg[DIR_BIT]) begin
								state_next = ST_RDATA;
								sh_next = mem[ptr_reg];
							end else begin
								state_next = ST_ADDR_HI;
							end
						end
					end
					ST_ADDR_HI: begin
						ahi_next = sh_reg[3:0];
						drive_next = 1'b1;
						ack_next = 1'b1;
						state_next = ST_ADDR_LO;
					end
					ST_ADDR_LO: begin
						ptr_next = {ahi_reg, sh_reg};
						drive_next = 1'b1;
						ack_next = 1'b1;
						state_next = ST_WDATA;
					end
					ST_WDATA: begin
						we = 1'b1;
						we_data = sh_reg;
						ptr_next = {ptr_reg[11:5], ptr_reg[4:0] + 5'd1};
						pend_next = 1'b1;
						drive_next = 1'b1;
						ack_next = 1'b1;
					end
					default: state_next = ST_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= ST_IDLE;
			bit_reg <= 4'd0;
			sh_reg <= 8'h00;
			ptr_reg <= ADDR_RST;
			ahi_reg <= 4'h0;
			ack_reg <= 1'b0;
			drive_reg <= 1'b0;
			pend_reg <= 1'b0;
			busy_cnt_reg <= 32'd0;
		end else begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			ptr_reg <= ptr_next;
			ahi_reg <= ahi_next;
			ack_reg <= ack_next;
			drive_reg <= drive_next;
			pend_reg <= pend_next;
			busy_cnt_reg <= busy_cnt_next;
		end
	end

	// ----------------------------------------
	// array
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (we)
			mem[we_addr] <= we_data;
	end

	assign LINK.sda_dev_oe = drive_reg;
	assign BUSY = (busy_cnt_reg != 0);
endmodule : eeprom_dev

// File: hdl/eeprom_host.sv
// host end: bit engine, commands, two-entry read buffer
`timescale 1ns/100ps
module eeprom_host
	import eeprom_link_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// link
	eeprom_link_if.host LINK,
	// command
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire host_cmd_t CMD_KIND,
	input wire logic [2:0] CMD_SELECT,
	input wire logic [11:0] CMD_ADDR,
	input wire logic [7:0] CMD_WDATA,
	input wire logic [7:0] CMD_COUNT,
	// read data stream
	output logic RD_VALID,
	input wire logic RD_READY,
	output logic [7:0] RD_DATA,
	// status
	output logic DONE,
	output logic NACKED
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_START = 3'b001,
		H_BYTE = 3'b010,
		H_RBYTE = 3'b011,
		H_STOP = 3'b100
	} host_state_t;

	host_state_t st_reg, st_next;
	logic [15:0] div_reg, div_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh_reg, sh_next;
	logic [2:0] step_reg, step_next;
	logic [7:0] cnt_reg, cnt_next;
	logic scl_reg, scl_next, oe_reg, oe_next;
	logic done_reg, done_next, nack_reg, nack_next;
	host_cmd_t kind_reg, kind_next;
	logic [2:0] sel_reg, sel_next;
	logic [11:0] addr_reg, addr_next;
	logic [7:0] wd_reg, wd_next;
	logic [1:0] sda_sync_reg;
	logic [7:0] buf_reg [BUF_DEPTH];
	logic [1:0] fill_reg;
	logic wptr_reg, rptr_reg;
	logic push, pop, tick, buf_ready;

	// ----------------------------------------
	// read buffer
	// ----------------------------------------
	assign buf_ready = (fill_reg != 2'd2);
	assign pop = RD_VALID & RD_READY;
	assign RD_VALID = (fill_reg != 2'd0);
	assign RD_DATA = buf_reg[rptr_reg];
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			fill_reg <= 2'd0;
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
		end else begin
			fill_reg <= fill_reg + {1'b0, push} - {1'b0, pop};
			if (push)
				wptr_reg <= ~wptr_reg;
			if (pop)
				rptr_reg <= ~rptr_reg;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (push)
			buf_reg[wptr_reg] <= sh_reg;
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST)
			sda_sync_reg <= 2'b11;
		else
			sda_sync_reg <= {sda_sync_reg[0], LINK.sda_line};
	end

	// ----------------------------------------
	// sequencer: quarter-bit phases
	// ----------------------------------------
	assign tick = (div_reg == 16'd0);
	assign CMD_READY = (st_reg == H_IDLE);
	always_comb begin
		st_next = st_reg;
		div_next = tick ? 16'(SCL_HALF_CYC / 2 - 1) : div_reg - 16'd1;
		ph_next = ph_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		step_next = step_reg;
		cnt_next = cnt_reg;
		scl_next = scl_reg;
		oe_next = oe_reg;
		done_next = 1'b0;
		nack_next = nack_reg;
		kind_next = kind_reg;
		sel_next = sel_reg;
		addr_next = addr_reg;
		wd_next = wd_reg;
		push = 1'b0;
		case (st_reg)
		H_IDLE: begin
			if (CMD_VALID) begin
				kind_next = CMD_KIND;
				sel_next = CMD_SELECT;
				addr_next = CMD_ADDR;
				wd_next = CMD_WDATA;
				cnt_next = CMD_COUNT;
				nack_next = 1'b0;
				step_next = 3'd0;
				ph_next = 2'd0;
				st_next = H_START;
			end
		end
		H_START: if (tick) begin
			ph_next = ph_reg + 2'd1;
			case (ph_reg)
			2'd0: begin scl_next = 1'b1; oe_next = 1'b0; end
			2'd1: oe_next = 1'b1;
			2'd2: scl_next = 1'b0;
			default: begin
				bit_next = 4'd0;
				ph_next = 2'd0;
				st_next = H_BYTE;
				// control byte: read on step 3 or plain current read
				sh_next = {TYPE_CODE, sel_reg,
					(step_reg == 3'd3) || (kind_reg == CMD_CUR_READ)};
			end
			endcase
		end
		H_BYTE, H_RBYTE: if (tick && (st_reg == H_BYTE || buf_ready ||
			bit_reg != 4'd8 || ph_reg != 2'd0)) begin
			ph_next = ph_reg + 2'd1;
			case (ph_reg)
			2'd0: begin
				if (st_reg == H_BYTE)
					oe_next = (bit_reg < 4'd8) ? ~sh_reg[7] : 1'b0;
				else
					oe_next = (bit_reg == 4'd8) && (cnt_reg != 8'd1);
			end
			2'd1: scl_next = 1'b1;
			2'd2: begin
				if (st_reg == H_RBYTE && bit_reg < 4'd8)
					sh_next = {sh_reg[6:0], sda_sync_reg[1]};
				else if (bit_reg < 4'd8)
					sh_next = {sh_reg[6:0], 1'b0};
				else if (st_reg == H_BYTE && sda_sync_reg[1])
					nack_next = 1'b1;
			end
			default: begin
				scl_next = 1'b0;
				bit_next = bit_reg + 4'd1;
				if (st_reg == H_RBYTE && bit_reg == 4'd7)
					push = 1'b1;
				if (bit_reg == 4'd8) begin
					bit_next = 4'd0;
					oe_next = 1'b0;
					if (st_reg == H_RBYTE) begin
						cnt_next = cnt_reg - 8'd1;
						if (cnt_reg == 8'd1)
							st_next = H_STOP;
					end else if (nack_reg) begin
						// poll: retry start and control byte
						st_next = (kind_reg == CMD_POLL) ? H_START : H_STOP;
						nack_next = (kind_reg == CMD_POLL) ? 1'b0 : 1'b1;
					end else begin
						step_next = step_reg + 3'd1;
						case (step_reg)
						3'd0: begin
							if (kind_reg == CMD_CUR_READ)
								st_next = H_RBYTE;
							else if (kind_reg == CMD_POLL)
								st_next = H_STOP;
							else
								sh_next = {4'h0, addr_reg[11:8]};
						end
						3'd1: sh_next = addr_reg[7:0];
						3'd2: begin
							if (kind_reg == CMD_RAND_READ)
								st_next = H_START;
							else
								sh_next = wd_reg;
						end
						3'd3: begin
							if (kind_reg == CMD_RAND_READ)
								st_next = H_RBYTE;
							else
								st_next = H_STOP;
						end
						default: st_next = H_STOP;
						endcase
					end
				end
			end
			endcase
		end
		H_STOP: if (tick) begin
			ph_next = ph_reg + 2'd1;
			case (ph_reg)
			2'd0: oe_next = 1'b1;
			2'd1: scl_next = 1'b1;
			2'd2: oe_next = 1'b0;
			default: begin
				ph_next = 2'd0;
				done_next = 1'b1;
				st_next = H_IDLE;
			end
			endcase
		end
		default: st_next = H_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			st_reg <= H_IDLE;
			div_reg <= 16'd0;
			ph_reg <= 2'd0;
			bit_reg <= 4'd0;
			sh_reg <= 8'h00;
			step_reg <= 3'd0;
			cnt_reg <= 8'd0;
			scl_reg <= 1'b1;
			oe_reg <= 1'b0;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
			kind_reg <= CMD_WRITE;
			sel_reg <= 3'd0;
			addr_reg <= 12'h000;
			wd_reg <= 8'h00;
		end else begin
			st_reg <= st_next;
			div_reg <= div_next;
			ph_reg <= ph_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			step_reg <= step_next;
			cnt_reg <= cnt_next;
			scl_reg <= scl_next;
			oe_reg <= oe_next;
			done_reg <= done_next;
			nack_reg <= nack_next;
			kind_reg <= kind_next;
			sel_reg <= sel_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
		end
	end

	assign LINK.scl = scl_reg;
	assign LINK.sda_host_oe = oe_reg;
	assign DONE = done_reg;
	assign NACKED = nack_reg;
endmodule : eeprom_host

// File: verification/eeprom_link_chk.sv
// checker of device behaviour on the two-wire link
`timescale 1ns/100ps
module eeprom_link_chk
	import eeprom_link_pkg::*;
#(
	parameter int WRITE_CYC = 200,
	parameter logic [2:0] DEV_SEL = 3'h0
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// link
	input wire logic scl,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic sda_line,
	// status
	input wire logic BUSY
);
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic scl_d_reg, sda_d_reg, idle_reg, mute_reg;
	logic [2:0] scl_p_reg;
	logic busy_dec_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [15:0] busy_reg;
	logic rise, start, stop, ack_exp;
	assign rise = scl & ~scl_d_reg;
	assign start = scl & scl_d_reg & sda_d_reg & ~sda_line;
	assign stop = scl & scl_d_reg & ~sda_d_reg & sda_line;
	// busy as seen where the device decodes, two syncs after the fall
	assign ack_exp = shift_reg[7:4] == TYPE_CODE &&
		shift_reg[3:1] == DEV_SEL && !busy_dec_reg;
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			idle_reg <= 1'b1;
			mute_reg <= 1'b0;
			cnt_reg <= 4'hf;
			shift_reg <= 8'h00;
			busy_reg <= 16'h0000;
			scl_p_reg <= 3'b111;
			busy_dec_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl;
			scl_p_reg <= {scl_p_reg[1:0], scl};
			if (!scl_p_reg[1] && scl_p_reg[2] && cnt_reg == 4'h8)
				busy_dec_reg <= BUSY;
			sda_d_reg <= sda_line;
			busy_reg <= BUSY ? busy_reg + 16'h0001 : 16'h0000;
			if (rise) shift_reg <= {shift_reg[6:0], sda_line};
			if (start) cnt_reg <= 4'h0;
			else if (stop) cnt_reg <= 4'hf;
			else if (rise && cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
			if (start) idle_reg <= 1'b0;
			else if (stop) idle_reg <= 1'b1;
			if (start) mute_reg <= 1'b0;
			else if (rise && cnt_reg == 4'h8 && !ack_exp) mute_reg <= 1'b1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	sequence ctrl_end;
		rise && cnt_reg == 4'h8;
	endsequence
	sequence dev_low_bit;
		$rose(scl) && sda_dev_oe;
	endsequence
	a_busy_quiet:
	assert property (BUSY |-> !sda_dev_oe) else $error("driven while busy");
	a_ctrl_ack:
	assert property (ctrl_end |-> sda_dev_oe == ack_exp)
		else $error("control byte answer wrong");
	a_ctrl_quiet:
	assert property (cnt_reg < 4'h8 |-> !sda_dev_oe)
		else $error("driven during control byte");
	a_stays_silent:
	assert property (idle_reg || mute_reg |-> !sda_dev_oe)
		else $error("driven while not addressed");
	a_change_low:
	assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("data changed with clock high");
	a_bit_stands:
	assert property (dev_low_bit |=> sda_dev_oe [*8])
		else $error("driven bit not held");
	a_busy_at_stop:
	assert property ($rose(BUSY) |-> scl && sda_line)
		else $error("write cycle began off a stop");
	a_busy_length:
	assert property ($fell(BUSY) |->
		busy_reg >= WRITE_CYC - 1 && busy_reg <= WRITE_CYC + 1)
		else $error("write cycle length wrong");
endmodule : eeprom_link_chk

// File: verification/tb.sv
// testbench: host and device ends joined over the link
`timescale 1ns/100ps
module tb import eeprom_link_pkg::*;;
	localparam logic [2:0] S = 3'h5;
	// long enough that a poll right after a write is refused
	localparam int WCYC = 1000;
	localparam host_cmd_t W = CMD_WRITE;
	localparam host_cmd_t C = CMD_CUR_READ;
	localparam host_cmd_t R = CMD_RAND_READ;
	localparam host_cmd_t P = CMD_POLL;
	typedef struct packed {
		host_cmd_t kind;
		logic [2:0] sel;
		logic [11:0] addr;
		logic [7:0] data;
		logic [7:0] count;
		logic nack;
	} row_t;
	logic REF_CLK, NRST, CMD_VALID, CMD_READY, RD_VALID, RD_READY;
	logic DONE, NACKED, BUSY;
	host_cmd_t CMD_KIND;
	logic [2:0] CMD_SELECT;
	logic [11:0] CMD_ADDR;
	logic [7:0] CMD_WDATA, CMD_COUNT, RD_DATA;
	int fails, compares, cycles;
	logic [7:0] mem [logic [11:0]];
	logic [11:0] ptr;
	row_t rows [19];
	eeprom_link_if link ();
	eeprom_host eeprom_host_i (.REF_CLK(REF_CLK), .NRST(NRST), .LINK(link),
		.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_KIND(CMD_KIND),
		.CMD_SELECT(CMD_SELECT), .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA),
		.CMD_COUNT(CMD_COUNT), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
		.RD_DATA(RD_DATA), .DONE(DONE), .NACKED(NACKED));
	eeprom_dev #(.WRITE_CYC(WCYC)) eeprom_dev_i (.REF_CLK(REF_CLK),
		.NRST(NRST), .LINK(link), .CHIP_SELECT_HIGH_BIT(S[2]),
		.CHIP_SELECT_MID_BIT(S[1]), .CHIP_SELECT_LOW_BIT(S[0]), .BUSY(BUSY));
	eeprom_link_chk #(.WRITE_CYC(WCYC), .DEV_SEL(S)) eeprom_link_chk_i (
		.REF_CLK(REF_CLK), .NRST(NRST), .scl(link.scl),
		.sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
		.sda_line(link.sda_line), .BUSY(BUSY));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic run_cmd(input row_t r);
		logic [7:0] got [$];
		int n;
		int m;
		@(posedge REF_CLK);
		#1;
		CMD_VALID = 1'b1;
		CMD_KIND = r.kind;
		CMD_SELECT = r.sel;
		CMD_ADDR = r.addr;
		CMD_WDATA = r.data;
		CMD_COUNT = r.count;
		do @(negedge REF_CLK); while (CMD_READY !== 1'b1);
		@(posedge REF_CLK);
		#1;
		CMD_VALID = 1'b0;
		n = 0;
		m = 0;
		while (n < 40000 && m < 4) begin
			@(negedge REF_CLK);
			if (RD_VALID === 1'b1 && RD_READY === 1'b1) got.push_back(RD_DATA);
			if (DONE === 1'b1 || m > 0) m++;
			n++;
		end
		check({7'h0, NACKED}, {7'h0, r.nack});
		if (r.kind == P) check({7'h0, BUSY}, 8'h0);
		if (!r.nack && r.kind == W) begin
			mem[r.addr] = r.data;
			ptr = {r.addr[11:5], r.addr[4:0] + 5'h01};
		end
		if (!r.nack && r.kind == R) ptr = r.addr;
		n = (r.nack || r.kind == W || r.kind == P) ? 0 : int'(r.count);
		check(8'(got.size()), 8'(n));
		for (int i = 0; i < n; i++) begin
			if (i < got.size()) check(got[i], mem[ptr]);
			ptr++;
		end
	endtask : run_cmd
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		REF_CLK = 1'b0;
		forever #25 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		NRST = 1'b0;
		CMD_VALID = 1'b0;
		CMD_KIND = W;
		CMD_SELECT = 3'h0;
		CMD_ADDR = 12'h000;
		CMD_WDATA = 8'h00;
		CMD_COUNT = 8'h00;
		RD_READY = 1'b1;
		fails = 0;
		compares = 0;
		cycles = 0;
		ptr = ADDR_RST;
		rows = '{'{W, S, 12'h123, 8'ha5, 8'h0, 1'b0}, '{P, S, 12'h0, 8'h0, 8'h0, 1'b0},
			'{W, S, 12'h124, 8'h3c, 8'h0, 1'b0}, '{P, S, 12'h0, 8'h0, 8'h0, 1'b0},
			'{R, S, 12'h123, 8'h0, 8'h2, 1'b0}, '{W, S, 12'h122, 8'h96, 8'h0, 1'b0},
			'{P, S, 12'h0, 8'h0, 8'h0, 1'b0}, '{C, S, 12'h0, 8'h0, 8'h1, 1'b0},
			'{C, S, 12'h0, 8'h0, 8'h1, 1'b0}, '{W, S, 12'hfff, 8'h77, 8'h0, 1'b0},
			'{P, S, 12'h0, 8'h0, 8'h0, 1'b0}, '{W, S, 12'h000, 8'he1, 8'h0, 1'b0},
			'{R, S, 12'h000, 8'h0, 8'h1, 1'b1}, '{P, S, 12'h0, 8'h0, 8'h0, 1'b0},
			'{W, S, 12'h001, 8'hd2, 8'h0, 1'b0}, '{P, S, 12'h0, 8'h0, 8'h0, 1'b0},
			'{R, S, 12'hfff, 8'h0, 8'h2, 1'b0}, '{R, ~S, 12'h0, 8'h0, 8'h1, 1'b1},
			'{C, S, 12'h0, 8'h0, 8'h1, 1'b0}};
		repeat (10) @(posedge REF_CLK);
		#1;
		NRST = 1'b1;
		foreach (rows[i]) run_cmd(rows[i]);
		// receiver stall with three bytes in flight
		@(posedge REF_CLK);
		#1;
		RD_READY = 1'b0;
		fork
			run_cmd('{R, S, 12'h122, 8'h0, 8'h3, 1'b0});
			begin
				repeat (3000) @(posedge REF_CLK);
				#1;
				check({7'h0, RD_VALID}, 8'h1);
				check({7'h0, DONE}, 8'h0);
				RD_READY = 1'b1;
			end
		join
		// reset in mid transfer
		@(posedge REF_CLK);
		#1;
		CMD_KIND = R;
		CMD_VALID = 1'b1;
		@(posedge REF_CLK);
		#1;
		CMD_VALID = 1'b0;
		repeat (600) @(posedge REF_CLK);
		#1;
		NRST = 1'b0;
		@(negedge REF_CLK);
		check({6'h0, link.scl, link.sda_line}, 8'h3);
		check({4'h0, CMD_READY, RD_VALID, DONE, BUSY}, 8'h8);
		repeat (3) @(posedge REF_CLK);
		#1;
		NRST = 1'b1;
		ptr = ADDR_RST;
		run_cmd('{P, S, 12'h0, 8'h0, 8'h0, 1'b0});
		report_and_stop();
	end
endmodule : tb
